// [src/rsq_pkg.sv]
// rsq_pkg: shared constants, types and register map of the receive signal qualifiers
package rsq_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODEM_CONFIG_TWO   = 8'h00;
    localparam logic [7:0] ADDR_PACKET_CONTROL_ONE = 8'h04;
    localparam logic [7:0] ADDR_GAIN_CONTROL_ZERO  = 8'h08;
    localparam logic [7:0] ADDR_GAIN_CONTROL_ONE   = 8'h0C;
    localparam logic [7:0] ADDR_GAIN_CONTROL_TWO   = 8'h10;
    localparam logic [7:0] ADDR_GP_OUTPUT_CONFIG   = 8'h14;
    localparam logic [7:0] ADDR_RSSI_STATUS        = 8'h18;
    localparam logic [7:0] ADDR_PACKET_STATUS      = 8'h1C;
    localparam logic [7:0] ADDR_RATE_BASE          = 8'h20;
    localparam logic [7:0] ADDR_CS_BASE            = 8'h24;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SYNC_MODE_LSB  = 0;
    localparam int PQT_LSB        = 5;
    localparam int APPEND_BIT     = 2;
    localparam int FILT_LEN_LSB   = 0;
    localparam int ABS_OFS_LSB    = 0;
    localparam int REL_STEP_LSB   = 4;
    localparam int TGT_MAG_LSB    = 0;
    localparam int FRONT_GAIN_LSB = 3;
    localparam int DIG_GAIN_LSB   = 6;
    localparam int STAT_CS_BIT    = 6;
    localparam int STAT_PQ_BIT    = 5;
    localparam int STAT_SYNC_BIT  = 3;
    localparam int SYNC_CS_BIT    = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  MODEM_CONFIG_TWO_RST   = 8'h02;
    localparam logic [7:0]  PACKET_CONTROL_ONE_RST = 8'h04;
    localparam logic [7:0]  GAIN_CONTROL_ZERO_RST  = 8'h00;
    localparam logic [7:0]  GAIN_CONTROL_ONE_RST   = 8'h00;
    localparam logic [7:0]  GAIN_CONTROL_TWO_RST   = 8'h03;
    localparam logic [5:0]  GP_OUTPUT_CONFIG_RST   = 6'h00;
    localparam logic [15:0] RATE_BASE_RST          = 16'h0010;
    localparam logic [7:0]  CS_BASE_RST            = 8'hB0;

    // ------------------------------------------------------------------
    // encodings and arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [5:0] GPO_SEL_PQ      = 6'h08;
    localparam logic [5:0] GPO_SEL_CS      = 6'h0E;
    localparam logic [1:0] SM_NONE         = 2'b00;
    localparam logic [1:0] SM_15_OF_16     = 2'b01;
    localparam logic [1:0] SM_16_OF_16     = 2'b10;
    localparam logic [1:0] SM_30_OF_32     = 2'b11;
    localparam logic [5:0] SYNC16_LOOSE    = 6'h0F;
    localparam logic [5:0] SYNC16_FULL     = 6'h10;
    localparam logic [5:0] SYNC32_LOOSE    = 6'h1E;
    localparam logic [7:0] PQ_INC          = 8'h01;
    localparam logic [7:0] PQ_DEC          = 8'h08;
    localparam logic [7:0] PQ_MAX          = 8'hFF;
    localparam logic [3:0] ABS_OFS_NEG_MAX = 4'h9;
    localparam logic [9:0] CS_HYST         = 10'h002;
    localparam logic [1:0] REL_OFF         = 2'b00;
    localparam logic [1:0] REL_6DB         = 2'b01;
    localparam logic [1:0] REL_10DB        = 2'b10;
    localparam logic [9:0] REL_STEP_6      = 10'h00C;
    localparam logic [9:0] REL_STEP_10     = 10'h014;
    localparam logic [9:0] REL_STEP_14     = 10'h01C;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       bit_valid;
        logic       bit_val;
        logic       sync_check;
        logic [5:0] match16;
        logic [5:0] match32;
        logic [7:0] rssi_raw;
    } rsq_demod_s;

    typedef struct packed {
        logic [2:0]  sync_mode;
        logic [2:0]  preamble_quality_threshold;
        logic        append_en;
        logic [1:0]  filt_len;
        logic [3:0]  abs_ofs;
        logic [1:0]  rel_step;
        logic [2:0]  tgt_mag;
        logic [2:0]  front_gain;
        logic [1:0]  dig_gain;
        logic [5:0]  gpo_sel;
        logic [15:0] rate_base;
        logic [7:0]  cs_base;
    } rsq_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SEARCH = 3'b010,
        ST_LOCKED = 3'b100
    } rsq_sync_e;

endpackage : rsq_pkg

// [src/rsq_rate_div.sv]
// rsq_rate_div: signal strength sample rate divider
`timescale 1ns/1ps
module rsq_rate_div (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [15:0] base_i,
    input  wire logic [1:0]  shift_i,
    output logic             tick_o
);
    logic [17:0] cnt_r;
    logic [17:0] period;

    // zero base would stall the sampler, so treat it as one
    assign period = (base_i == 16'h0000) ? 18'h00001 : ({2'b00, base_i} << shift_i);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_r  <= 18'h00000;
            tick_o <= 1'b0;
        end else if (cnt_r >= period - 18'h00001) begin
            cnt_r  <= 18'h00000;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 18'h00001;
            tick_o <= 1'b0;
        end
    end

endmodule : rsq_rate_div

// [src/rsq_top.sv]
// rsq_top: sync qualifiers, preamble quality, signal strength hold and carrier sense
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - with sync detection on, no fifo writes or filtering before accepted sync.
// - mode low bits: none, 15 of 16, 16 of 16, 30 of 32 sync bits.
// - modes 100-111 repeat 000-011 and also need carrier sense.
// - with quality gating on, sync needs preamble quality above threshold.
// - quality counter adds one per toggled bit, subtracts eight per repeated bit.
// - counter is compared against four times the threshold field.
// - threshold field zero drops the quality condition entirely.
// - quality-met flag on gp output code 8 and packet status bit.
// - with sync detection on, signal strength tracks until sync, then holds until receive re-entry.
// - signal strength reads as two's complement half-dB units, uncorrected.
// - samples at base period times two to the filter length.
// - strength captured at sync goes into first appended status byte.
// - absolute mode asserts above level, deasserts below it with hysteresis.
// - relative mode asserts on rise by step, deasserts on fall by step.
// - carrier-qualified modes search only while carrier sense is set.
// - carrier sense on gp output code 14 and packet status bit.
// - offset field moves absolute level by plus/minus 7 dB in 1 dB steps.
// - relative field selects off, 6, 10 or 14 dB.
// - reset leaves offset zero and target magnitude three.
module rsq_top (
    input  wire logic               CLK_I,
    input  wire logic               RST_I,
    input  wire logic               PSEL_I,
    input  wire logic               PENABLE_I,
    input  wire logic               PWRITE_I,
    input  wire logic [7:0]         PADDR_I,
    input  wire logic [31:0]        PWDATA_I,
    output logic [31:0]             PRDATA_O,
    output logic                    PREADY_O,
    output logic                    PSLVERR_O,
    input  wire logic               RX_ACTIVE_I,
    input  wire logic               RX_ENTER_I,
    input  wire rsq_pkg::rsq_demod_s DEMOD_I,
    output logic                    SYNC_FOUND_O,
    output logic                    RX_GATE_O,
    output logic [7:0]              APPEND_RSSI_O,
    output logic                    APPEND_VALID_O,
    output logic                    CARRIER_SENSE_O,
    output logic                    PREAMBLE_QUALITY_MET_O,
    output logic                    GP_OUTPUT_PIN_O,
    output logic [2:0]              TARGET_MAGNITUDE_O,
    output logic [2:0]              FRONT_AMP_GAIN_LIMIT_O,
    output logic [1:0]              DIGITAL_AMP_GAIN_LIMIT_O
);
    import rsq_pkg::*;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [9:0] sx10(input logic [7:0] v);
        sx10 = {{2{v[7]}}, v};
    endfunction : sx10

    // signed a > b over 10 bits
    function automatic logic sgt(input logic [9:0] a, input logic [9:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction : sgt

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    rsq_cfg_s   cfg_r;
    rsq_sync_e  sync_st_r;
    rsq_sync_e  sync_st_nxt;
    logic [7:0] pq_cnt_r;
    logic       prev_bit_r;
    logic       have_prev_r;
    logic [7:0] rssi_r;
    logic [7:0] rssi_prev_r;
    logic       have_sample_r;
    logic       rssi_frozen_r;
    logic [7:0] append_rssi_r;
    logic       abs_cs_r;
    logic       rel_cs_r;
    logic       sync_pulse_r;
    logic [31:0] prdata_r;
    logic       sample_tick;
    logic       pq_met;
    logic       cs;
    logic       pq_ok;
    logic       cs_ok;
    logic       match_ok;
    logic       sync_accept;
    logic       sync_enabled;
    logic [3:0] ofs_clamped;
    logic [9:0] abs_level;
    logic [9:0] rel_step;
    logic [9:0] rssi_x;
    logic [9:0] rssi_prev_x;
    logic [9:0] raw_x;
    logic       wr_en;
    logic       rd_setup;
    logic       addr_hit;
    logic [7:0] status_byte;

    // ------------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------
    assign wr_en    = PSEL_I && PENABLE_I && PWRITE_I && addr_hit;
    assign rd_setup = PSEL_I && !PENABLE_I;

    assign addr_hit = PADDR_I inside {
            ADDR_MODEM_CONFIG_TWO, ADDR_PACKET_CONTROL_ONE, ADDR_GAIN_CONTROL_ZERO,
            ADDR_GAIN_CONTROL_ONE, ADDR_GAIN_CONTROL_TWO, ADDR_GP_OUTPUT_CONFIG,
            ADDR_RSSI_STATUS, ADDR_PACKET_STATUS, ADDR_RATE_BASE, ADDR_CS_BASE};

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cfg_r.sync_mode  <= MODEM_CONFIG_TWO_RST[SYNC_MODE_LSB +: 3];
            cfg_r.preamble_quality_threshold        <= PACKET_CONTROL_ONE_RST[PQT_LSB +: 3];
            cfg_r.append_en  <= PACKET_CONTROL_ONE_RST[APPEND_BIT];
            cfg_r.filt_len   <= GAIN_CONTROL_ZERO_RST[FILT_LEN_LSB +: 2];
            cfg_r.abs_ofs    <= GAIN_CONTROL_ONE_RST[ABS_OFS_LSB +: 4];
            cfg_r.rel_step   <= GAIN_CONTROL_ONE_RST[REL_STEP_LSB +: 2];
            cfg_r.tgt_mag    <= GAIN_CONTROL_TWO_RST[TGT_MAG_LSB +: 3];
            cfg_r.front_gain <= GAIN_CONTROL_TWO_RST[FRONT_GAIN_LSB +: 3];
            cfg_r.dig_gain   <= GAIN_CONTROL_TWO_RST[DIG_GAIN_LSB +: 2];
            cfg_r.gpo_sel    <= GP_OUTPUT_CONFIG_RST;
            cfg_r.rate_base  <= RATE_BASE_RST;
            cfg_r.cs_base    <= CS_BASE_RST;
        end else if (wr_en) begin
            unique case (PADDR_I)
                ADDR_MODEM_CONFIG_TWO: cfg_r.sync_mode <= PWDATA_I[SYNC_MODE_LSB +: 3];
                ADDR_PACKET_CONTROL_ONE: begin
                    cfg_r.preamble_quality_threshold       <= PWDATA_I[PQT_LSB +: 3];
                    cfg_r.append_en <= PWDATA_I[APPEND_BIT];
                end
                ADDR_GAIN_CONTROL_ZERO: cfg_r.filt_len <= PWDATA_I[FILT_LEN_LSB +: 2];
                ADDR_GAIN_CONTROL_ONE: begin
                    cfg_r.abs_ofs  <= PWDATA_I[ABS_OFS_LSB +: 4];
                    cfg_r.rel_step <= PWDATA_I[REL_STEP_LSB +: 2];
                end
                ADDR_GAIN_CONTROL_TWO: begin
                    cfg_r.tgt_mag    <= PWDATA_I[TGT_MAG_LSB +: 3];
                    cfg_r.front_gain <= PWDATA_I[FRONT_GAIN_LSB +: 3];
                    cfg_r.dig_gain   <= PWDATA_I[DIG_GAIN_LSB +: 2];
                end
                ADDR_GP_OUTPUT_CONFIG: cfg_r.gpo_sel <= PWDATA_I[5:0];
                ADDR_RATE_BASE: cfg_r.rate_base <= PWDATA_I[15:0];
                ADDR_CS_BASE: cfg_r.cs_base <= PWDATA_I[7:0];
                default: ;
            endcase
        end
    end

    assign status_byte = {1'b0, cs, pq_met, 1'b0, (sync_st_r == ST_LOCKED), 3'b000};

    // read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            prdata_r <= 32'h00000000;
        end else if (rd_setup) begin
            unique case (PADDR_I)
                ADDR_MODEM_CONFIG_TWO:   prdata_r <= {29'h0, cfg_r.sync_mode};
                ADDR_PACKET_CONTROL_ONE: prdata_r <= {24'h0, cfg_r.preamble_quality_threshold, 2'b00, cfg_r.append_en, 2'b00};
                ADDR_GAIN_CONTROL_ZERO:  prdata_r <= {30'h0, cfg_r.filt_len};
                ADDR_GAIN_CONTROL_ONE:   prdata_r <= {26'h0, cfg_r.rel_step, cfg_r.abs_ofs};
                ADDR_GAIN_CONTROL_TWO:   prdata_r <= {24'h0, cfg_r.dig_gain, cfg_r.front_gain, cfg_r.tgt_mag};
                ADDR_GP_OUTPUT_CONFIG:   prdata_r <= {26'h0, cfg_r.gpo_sel};
                ADDR_RSSI_STATUS:        prdata_r <= {24'h0, rssi_r};
                ADDR_PACKET_STATUS:      prdata_r <= {24'h0, status_byte};
                ADDR_RATE_BASE:          prdata_r <= {16'h0, cfg_r.rate_base};
                ADDR_CS_BASE:            prdata_r <= {24'h0, cfg_r.cs_base};
                default:                 prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign PRDATA_O  = prdata_r;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

    // ------------------------------------------------------------------
    // preamble quality
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I || RX_ENTER_I) begin
            pq_cnt_r    <= 8'h00;
            prev_bit_r  <= 1'b0;
            have_prev_r <= 1'b0;
        end else if (DEMOD_I.bit_valid) begin
            prev_bit_r  <= DEMOD_I.bit_val;
            have_prev_r <= 1'b1;
            if (have_prev_r && DEMOD_I.bit_val != prev_bit_r) begin
                if (pq_cnt_r != PQ_MAX) begin
                    pq_cnt_r <= pq_cnt_r + PQ_INC;
                end
            end else if (have_prev_r) begin
                // floor at zero; a wrap would fake a strong preamble
                pq_cnt_r <= (pq_cnt_r > PQ_DEC) ? pq_cnt_r - PQ_DEC : 8'h00;
            end
        end
    end

    assign pq_met = pq_cnt_r > {3'b000, cfg_r.preamble_quality_threshold, 2'b00};
    assign pq_ok  = (cfg_r.preamble_quality_threshold == 3'b000) || pq_met;

    // ------------------------------------------------------------------
    // signal strength sampling and hold
    // ------------------------------------------------------------------
    rsq_rate_div u_rate (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .run_i   (RX_ACTIVE_I),
        .base_i  (cfg_r.rate_base),
        .shift_i (cfg_r.filt_len),
        .tick_o  (sample_tick)
    );

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rssi_r        <= 8'h80;
            rssi_prev_r   <= 8'h80;
            have_sample_r <= 1'b0;
        end else if (RX_ENTER_I) begin
            have_sample_r <= 1'b0;
        end else if (sample_tick) begin
            rssi_prev_r   <= DEMOD_I.rssi_raw;
            have_sample_r <= 1'b1;
            if (!rssi_frozen_r && !(sync_accept && sync_enabled)) begin
                rssi_r <= DEMOD_I.rssi_raw;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || RX_ENTER_I) begin
            rssi_frozen_r <= 1'b0;
        end else if (sync_accept && sync_enabled) begin
            rssi_frozen_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            append_rssi_r <= 8'h00;
        end else if (sync_accept) begin
            append_rssi_r <= rssi_r;
        end
    end

    // ------------------------------------------------------------------
    // carrier sense
    // ------------------------------------------------------------------
    // the 1000 code would reach -8 dB, so clamp to the documented span
    assign ofs_clamped = (cfg_r.abs_ofs == 4'h8) ? ABS_OFS_NEG_MAX : cfg_r.abs_ofs;
    assign abs_level   = sx10(cfg_r.cs_base) + {{5{ofs_clamped[3]}}, ofs_clamped, 1'b0};
    assign rssi_x      = sx10(rssi_r);
    assign rssi_prev_x = sx10(rssi_prev_r);
    assign raw_x       = sx10(DEMOD_I.rssi_raw);

    always_comb begin
        unique case (cfg_r.rel_step)
            REL_OFF:  rel_step = 10'h000;
            REL_6DB:  rel_step = REL_STEP_6;
            REL_10DB: rel_step = REL_STEP_10;
            default:  rel_step = REL_STEP_14;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || !RX_ACTIVE_I) begin
            abs_cs_r <= 1'b0;
        end else if (sample_tick) begin
            if (sgt(raw_x, abs_level)) begin
                abs_cs_r <= 1'b1;
            end else if (sgt(abs_level - CS_HYST, raw_x)) begin
                abs_cs_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || !RX_ACTIVE_I || cfg_r.rel_step == REL_OFF) begin
            rel_cs_r <= 1'b0;
        end else if (sample_tick && have_sample_r) begin
            if (!sgt(rssi_prev_x + rel_step, raw_x)) begin
                rel_cs_r <= 1'b1;
            end else if (!sgt(raw_x, rssi_prev_x - rel_step)) begin
                rel_cs_r <= 1'b0;
            end
        end
    end

    assign cs = abs_cs_r || rel_cs_r;

    // ------------------------------------------------------------------
    // sync qualification
    // ------------------------------------------------------------------
    assign sync_enabled = cfg_r.sync_mode[1:0] != SM_NONE;
    assign cs_ok        = !cfg_r.sync_mode[SYNC_CS_BIT] || cs;

    always_comb begin
        unique case (cfg_r.sync_mode[1:0])
            SM_NONE:     match_ok = 1'b1;
            SM_15_OF_16: match_ok = DEMOD_I.match16 >= SYNC16_LOOSE;
            SM_16_OF_16: match_ok = DEMOD_I.match16 >= SYNC16_FULL;
            default:     match_ok = DEMOD_I.match32 >= SYNC32_LOOSE;
        endcase
    end

    assign sync_accept = (sync_st_r == ST_SEARCH) && RX_ACTIVE_I && cs_ok &&
                         (sync_enabled ? (DEMOD_I.sync_check && match_ok && pq_ok) : 1'b1);

    always_comb begin
        sync_st_nxt = sync_st_r;
        unique case (sync_st_r)
            ST_IDLE: begin
                if (RX_ACTIVE_I) begin
                    sync_st_nxt = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (!RX_ACTIVE_I) begin
                    sync_st_nxt = ST_IDLE;
                end else if (sync_accept) begin
                    sync_st_nxt = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                if (!RX_ACTIVE_I) begin
                    sync_st_nxt = ST_IDLE;
                end
            end
            default: sync_st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sync_st_r <= ST_IDLE;
        end else if (RX_ENTER_I) begin
            sync_st_r <= ST_SEARCH;
        end else begin
            sync_st_r <= sync_st_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sync_pulse_r <= 1'b0;
        end else begin
            sync_pulse_r <= sync_accept && !RX_ENTER_I;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RX_GATE_O               = (sync_st_r == ST_LOCKED) && RX_ACTIVE_I;
    assign SYNC_FOUND_O            = sync_pulse_r;
    assign APPEND_RSSI_O           = append_rssi_r;
    assign APPEND_VALID_O          = cfg_r.append_en && (sync_st_r == ST_LOCKED);
    assign CARRIER_SENSE_O         = cs;
    assign PREAMBLE_QUALITY_MET_O  = pq_met;
    assign GP_OUTPUT_PIN_O         = (cfg_r.gpo_sel == GPO_SEL_PQ) ? pq_met :
                                     (cfg_r.gpo_sel == GPO_SEL_CS) ? cs : 1'b0;
    // gain limits go to the agc; software lowers front gain first for a higher level
    assign TARGET_MAGNITUDE_O      = cfg_r.tgt_mag;
    assign FRONT_AMP_GAIN_LIMIT_O  = cfg_r.front_gain;
    assign DIGITAL_AMP_GAIN_LIMIT_O = cfg_r.dig_gain;

endmodule : rsq_top

// [sim/rsq_top_properties.sv]
// rsq_top_properties: port-level checks of the receive signal qualifiers
`timescale 1ns/1ps
module rsq_top_properties (
    input wire logic       CLK_I,
    input wire logic       RST_I,
    input wire logic       RX_ACTIVE_I,
    input wire logic       RX_ENTER_I,
    input wire logic       SYNC_FOUND_O,
    input wire logic       RX_GATE_O,
    input wire logic [7:0] APPEND_RSSI_O,
    input wire logic       CARRIER_SENSE_O,
    input wire logic       PREAMBLE_QUALITY_MET_O,
    input wire logic       GP_OUTPUT_PIN_O,
    input wire logic [2:0] TARGET_MAGNITUDE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_lock; $rose(RX_GATE_O); endsequence
    property p_gate; RX_GATE_O |-> RX_ACTIVE_I; endproperty
    a_gate: assert property (p_gate) else $error("gate open");
    property p_found; s_lock |-> SYNC_FOUND_O ##1 !SYNC_FOUND_O; endproperty
    a_found: assert property (p_found) else $error("found pulse");
    property p_hold; RX_GATE_O && $past(RX_GATE_O) |-> $stable(APPEND_RSSI_O); endproperty
    a_hold: assert property (p_hold) else $error("rssi moved");
    property p_csoff; !RX_ACTIVE_I |=> !CARRIER_SENSE_O; endproperty
    a_csoff: assert property (p_csoff) else $error("cs idle");
    property p_entry; RX_ENTER_I |=> !PREAMBLE_QUALITY_MET_O && !RX_GATE_O; endproperty
    a_entry: assert property (p_entry) else $error("entry");
    property p_pin; GP_OUTPUT_PIN_O |-> CARRIER_SENSE_O || PREAMBLE_QUALITY_MET_O; endproperty
    a_pin: assert property (p_pin) else $error("pin");
    property p_tgt; $fell(RST_I) |-> TARGET_MAGNITUDE_O == 3'h3; endproperty
    a_tgt: assert property (p_tgt) else $error("target");
    property p_lockd; SYNC_FOUND_O |-> RX_GATE_O; endproperty
    a_lockd: assert property (p_lockd) else $error("not locked");
endmodule : rsq_top_properties
bind rsq_top rsq_top_properties chk_i (.*);

// [sim/rsq_demod_model.sv]
// rsq_demod_model: demodulator stand-in for bits, sync counts and samples
`timescale 1ns/1ps
module rsq_demod_model (
    input  wire logic           clk_i,
    output rsq_pkg::rsq_demod_s demod_o
);
    import rsq_pkg::*;
    initial demod_o = '0;
    // one-cycle strobe; counts inverted afterwards and sync_check dropped so stale values are never accepted
    task automatic pulse(input logic v, input logic b, input logic s, input logic [5:0] m);
        @(posedge clk_i);
        demod_o <= '{v, b, s, m, ~m, demod_o.rssi_raw};
        @(posedge clk_i);
        demod_o <= '{1'b0, ~b, 1'b0, ~m, m, demod_o.rssi_raw};
    endtask : pulse
    task automatic level(input logic [7:0] r);
        @(posedge clk_i);
        demod_o.rssi_raw <= r;
    endtask : level
endmodule : rsq_demod_model

// [sim/rsq_top_tb.sv]
// rsq_top_tb: self-checking bench for the receive signal qualifiers
`timescale 1ns/1ps
module rsq_top_tb;
    import rsq_pkg::*;
    logic        CLK_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
    logic        RX_ACTIVE_I = 1'b0, RX_ENTER_I = 1'b0, e;
    logic [7:0]  PADDR_I = 8'h00, APPEND_RSSI_O;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, q;
    logic        PREADY_O, PSLVERR_O, SYNC_FOUND_O, RX_GATE_O, APPEND_VALID_O, CARRIER_SENSE_O;
    logic        PREAMBLE_QUALITY_MET_O, GP_OUTPUT_PIN_O;
    logic [2:0]  TARGET_MAGNITUDE_O, FRONT_AMP_GAIN_LIMIT_O;
    logic [1:0]  DIGITAL_AMP_GAIN_LIMIT_O;
    rsq_demod_s  DEMOD_I;
    int          fails = 0, checked = 0;
    // flags packed: gate, found, append, carrier, quality, pin
    wire logic [31:0] st = {26'h0, RX_GATE_O, SYNC_FOUND_O, APPEND_VALID_O,
                            CARRIER_SENSE_O, PREAMBLE_QUALITY_MET_O, GP_OUTPUT_PIN_O};
    always #5 CLK_I = ~CLK_I;
    rsq_top uut (.*);
    rsq_demod_model demod (.clk_i(CLK_I), .demod_o(DEMOD_I));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'b10, w, a, d};
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge CLK_I); while (PREADY_O !== 1'b1);
        {q, e} = {PRDATA_O, PSLVERR_O};
        {PSEL_I, PENABLE_I} <= 2'b00;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
        fails += int'(got !== exp);
    endtask : chk
    task automatic enter();
        @(posedge CLK_I);
        {RX_ACTIVE_I, RX_ENTER_I} <= 2'b11;
        @(posedge CLK_I);
        RX_ENTER_I <= 1'b0;
    endtask : enter
    task automatic t_reset();
        apb(1'b0, ADDR_MODEM_CONFIG_TWO, 32'h0);
        chk(q, 32'h2);
        apb(1'b0, ADDR_GAIN_CONTROL_ONE, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, ADDR_RSSI_STATUS, 32'h55);
        apb(1'b0, ADDR_RSSI_STATUS, 32'h0);
        chk(q, 32'h80);
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, ADDR_GAIN_CONTROL_TWO, 32'h5B);
        @(negedge CLK_I);
        chk({24'h0, DIGITAL_AMP_GAIN_LIMIT_O, FRONT_AMP_GAIN_LIMIT_O, TARGET_MAGNITUDE_O}, 32'h5B);
        $display("reset test done");
    endtask : t_reset
    task automatic t_lock();
        apb(1'b1, ADDR_PACKET_CONTROL_ONE, 32'h24);
        apb(1'b1, ADDR_GP_OUTPUT_CONFIG, {26'h0, GPO_SEL_PQ});
        demod.level(8'hC0);
        enter();
        repeat (40) @(posedge CLK_I);
        demod.pulse(1'b0, 1'b0, 1'b1, SYNC16_FULL);
        @(negedge CLK_I) chk(st, 32'h04);
        for (int i = 0; i < 5; i++) demod.pulse(1'b1, i[0], 1'b0, 6'h00);
        @(negedge CLK_I) chk(st, 32'h04);
        demod.pulse(1'b1, 1'b1, 1'b0, 6'h00);
        @(negedge CLK_I) chk(st, 32'h07);
        demod.pulse(1'b1, 1'b1, 1'b0, 6'h00);
        @(negedge CLK_I) chk(st, 32'h04);
        for (int i = 0; i < 6; i++) demod.pulse(1'b1, i[0], 1'b0, 6'h00);
        demod.pulse(1'b0, 1'b0, 1'b1, SYNC16_LOOSE);
        @(negedge CLK_I) chk(st, 32'h07);
        demod.pulse(1'b0, 1'b0, 1'b1, SYNC16_FULL);
        @(negedge CLK_I) chk(st, 32'h3F);
        chk({24'h0, APPEND_RSSI_O}, 32'hC0);
        demod.level(8'h90);
        repeat (40) @(posedge CLK_I);
        @(negedge CLK_I) chk(st, 32'h2B);
        apb(1'b0, ADDR_RSSI_STATUS, 32'h0);
        chk(q, 32'hC0);
        apb(1'b0, ADDR_PACKET_STATUS, 32'h0);
        chk(q, 32'h28);
        enter();
        repeat (40) @(posedge CLK_I);
        apb(1'b0, ADDR_RSSI_STATUS, 32'h0);
        chk(q, 32'h90);
        $display("lock test done");
    endtask : t_lock
    task automatic t_cs();
        apb(1'b1, ADDR_PACKET_CONTROL_ONE, 32'h04);
        apb(1'b1, ADDR_MODEM_CONFIG_TWO, 32'h5);
        apb(1'b1, ADDR_GP_OUTPUT_CONFIG, {26'h0, GPO_SEL_CS});
        demod.pulse(1'b0, 1'b0, 1'b1, SYNC16_LOOSE);
        @(negedge CLK_I) chk(st, 32'h00);
        demod.level(8'hC0);
        repeat (40) @(posedge CLK_I);
        demod.pulse(1'b0, 1'b0, 1'b1, SYNC16_LOOSE);
        @(negedge CLK_I) chk(st, 32'h3D);
        apb(1'b1, ADDR_CS_BASE, 32'h7F);
        apb(1'b1, ADDR_GAIN_CONTROL_ONE, 32'h10);
        demod.level(8'hD0);
        repeat (40) @(posedge CLK_I);
        @(negedge CLK_I) chk(st, 32'h2D);
        demod.level(8'hC0);
        repeat (40) @(posedge CLK_I);
        @(negedge CLK_I) chk(st, 32'h28);
        $display("carrier test done");
    endtask : t_cs
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge CLK_I);
        RST_I <= 1'b0;
        t_reset();
        t_lock();
        t_cs();
        give_verdict();
    end
endmodule : rsq_top_tb
